// ==== hdl/fsc_filter_cfg.v ====
// setup 0 filter configuration register and conversion pacing
// Notes on behaviour
// - 16-bit filter config register at 0x28, reset value 0x0500.
// - any write aborts the conversion and restarts from first channel.
// - bit 15 set turns bits 14..0 into a sinc3 decimation ratio.
// - in direct mode order, post-filter and rate fields are ignored.
// - direct single-channel word rate is modulator rate over 32 times ratio.
// - bits 14..12 reserved, read-only, reset zero; host writes zeros.
// - bit 7 reserved, read-only, reset zero; host writes zero.
// - bit 11 switches the mains post-filter on or off, reset zero.
// - post-filter acts only while order field is 00; host sets that.
// - bits 10..8 choose the mains post-filter, reset 0x5.
// - code 010: 27 SPS, 47 dB, 36.7 ms settling.
// - code 011: 21.25 SPS, 62 dB, 40 ms settling.
// - code 101: 20 SPS, 86 dB, 50 ms settling.
// - code 110: 16.67 SPS, 92 dB, 60 ms settling.
// - bits 6..5 set the digital filter order, reset zero.
// - order 00 is sinc5 plus sinc1; order 11 is sinc3.
// - bits 4..0 select output data rate, reset zero.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_filter_regs.vh"

module fsc_filter_cfg #(
  // divides every post-filter count; 1 keeps the real pace
  parameter [31:0] TIME_DIV = 32'd1,
  parameter [31:0] PLAIN_WORD_CYC = `FSC_PLAIN_WORD_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register access from the serial port
  input wire [5:0] reg_addr,
  input wire reg_wr_en,
  input wire [15:0] reg_wdata,
  input wire reg_rd_en,
  output wire [15:0] reg_rdata,
  // conversion control
  output wire conv_restart,
  output wire word_ready,
  output wire conv_settled,
  // decoded filter setup
  output wire direct_decimation_select,
  output wire [14:0] decim_ratio,
  output wire order_sinc5_sinc1,
  output wire order_sinc3,
  output wire mains_postfilter_on,
  output wire [2:0] mains_postfilter_choice,
  output wire [4:0] output_rate_field
);

  // conversion phases
  localparam [1:0] ST_RESTART = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  // post-filter settling and word periods in core cycles
  localparam [31:0] SETTLE_27_CYC = `FSC_SETTLE_27_US * `FSC_CLK_MHZ / TIME_DIV;
  localparam [31:0] SETTLE_21_CYC = `FSC_SETTLE_21_US * `FSC_CLK_MHZ / TIME_DIV;
  localparam [31:0] SETTLE_20_CYC = `FSC_SETTLE_20_US * `FSC_CLK_MHZ / TIME_DIV;
  localparam [31:0] SETTLE_16_CYC = `FSC_SETTLE_16_US * `FSC_CLK_MHZ / TIME_DIV;
  localparam [63:0] WORD_27_CYC =
    64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_27_CSPS / TIME_DIV;
  localparam [63:0] WORD_21_CYC =
    64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_21_CSPS / TIME_DIV;
  localparam [63:0] WORD_20_CYC =
    64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_20_CSPS / TIME_DIV;
  localparam [63:0] WORD_16_CYC =
    64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_16_CSPS / TIME_DIV;

  // settling and word period, post-filter paced, in core cycles
  function [23:0] pf_settle;
    input [2:0] code;
    begin
      case (code)
        `FSC_PF_27: pf_settle = SETTLE_27_CYC[23:0];
        `FSC_PF_21: pf_settle = SETTLE_21_CYC[23:0];
        `FSC_PF_20: pf_settle = SETTLE_20_CYC[23:0];
        `FSC_PF_16: pf_settle = SETTLE_16_CYC[23:0];
        default: pf_settle = 24'h000000;
      endcase
    end
  endfunction

  function [23:0] pf_word;
    input [2:0] code;
    begin
      case (code)
        `FSC_PF_27: pf_word = WORD_27_CYC[23:0];
        `FSC_PF_21: pf_word = WORD_21_CYC[23:0];
        `FSC_PF_20: pf_word = WORD_20_CYC[23:0];
        `FSC_PF_16: pf_word = WORD_16_CYC[23:0];
        default: pf_word = 24'h000000;
      endcase
    end
  endfunction

  // direct mode ticks per word, scaled by a word count
  function [23:0] direct_ticks;
    input [14:0] ratio;
    input [1:0] words;
    reg [23:0] one;
    begin
      one = {9'h000, ratio} * `FSC_DIRECT_MUL;
      direct_ticks = one * {22'h000000, words};
    end
  endfunction

  // register and pacing state
  reg [15:0] cfg_r;
  reg [15:0] cfg_nxt;
  reg [15:0] rdata_r;
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg restart_r;
  reg word_r;
  reg settled_r;
  reg [5:0] mod_cnt_r;
  reg mod_tick_r;
  reg direct_r;
  reg [14:0] ratio_r;
  reg sinc51_r;
  reg sinc3_r;
  reg pf_on_r;
  reg [2:0] pf_choice_r;
  reg [4:0] rate_r;
  reg [23:0] target;
  reg timer_tick;
  wire cfg_wr;
  wire cfg_rd;
  wire timer_hit;
  wire [15:0] wmask;
  wire pf_live;
  wire in_direct;

  assign cfg_wr = reg_wr_en && (reg_addr == `FSC_ADDR_FILTER_CFG);
  assign cfg_rd = reg_rd_en && (reg_addr == `FSC_ADDR_FILTER_CFG);
  assign in_direct = cfg_r[`FSC_DIRECT_BIT];

  // mapping follows the bit 15 being written, so a direct write
  // keeps all ratio bits while a normal write masks reserved bits
  assign wmask = reg_wdata[`FSC_DIRECT_BIT] ? `FSC_DIRECT_WMASK
                                            : `FSC_NORMAL_WMASK;

  // post-filter only when enabled, order 00 and not direct
  assign pf_live = cfg_r[`FSC_PF_EN_BIT] && !in_direct &&
    (cfg_r[`FSC_ORDER_MSB:`FSC_ORDER_LSB] == `FSC_ORDER_SINC5_SINC1);

  // next register value on a write
  always @* begin
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt = reg_wdata & wmask;
    end
  end

  // configuration register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `FSC_RST_FILTER_CFG;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // read data, captured on the read strobe
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd_en) begin
      if (cfg_rd) begin
        rdata_r <= cfg_r;
      end else begin
        rdata_r <= `FSC_RD_UNMAPPED;
      end
    end
  end

  // modulator tick divider; direct mode counts these ticks
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt_r <= 6'h00;
      mod_tick_r <= 1'b0;
    end else if (mod_cnt_r == (`FSC_MOD_DIV - 6'd1)) begin
      mod_cnt_r <= 6'h00;
      mod_tick_r <= 1'b1;
    end else begin
      mod_cnt_r <= mod_cnt_r + 6'h01;
      mod_tick_r <= 1'b0;
    end
  end

  // timer target per mode and phase
  always @* begin
    target = 24'h000000;
    timer_tick = 1'b1;
    if (in_direct) begin
      timer_tick = mod_tick_r;
      if (st_r == ST_SETTLE) begin
        target = direct_ticks(cfg_r[`FSC_RATIO_MSB:0],
                              2'd`FSC_SINC3_SETTLE_WORDS);
      end else begin
        target = direct_ticks(cfg_r[`FSC_RATIO_MSB:0], 2'd1);
      end
    end else if (pf_live) begin
      if (st_r == ST_SETTLE) begin
        target = pf_settle(cfg_r[`FSC_PF_CHOICE_MSB:`FSC_PF_CHOICE_LSB]);
      end else begin
        target = pf_word(cfg_r[`FSC_PF_CHOICE_MSB:`FSC_PF_CHOICE_LSB]);
      end
    end else begin
      // plain rate table lives elsewhere; fixed pace stands in here
      target = PLAIN_WORD_CYC[23:0];
    end
  end

  // pacing timer, cleared on every restart
  fsc_word_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(cfg_wr || (st_r == ST_RESTART)),
    .tick(timer_tick),
    .target(target),
    .hit_r(timer_hit)
  );

  // phase sequencing; a write wins over any timer hit
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_RESTART: st_nxt = ST_SETTLE;
      ST_SETTLE: begin
        if (timer_hit) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: st_nxt = ST_RUN;
      default: st_nxt = ST_RESTART;
    endcase
    if (cfg_wr) begin
      st_nxt = ST_RESTART;
    end
  end

  // phase register and conversion strobes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RESTART;
      restart_r <= 1'b0;
      word_r <= 1'b0;
      settled_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      restart_r <= cfg_wr;
      word_r <= timer_hit && !cfg_wr;
      if (cfg_wr) begin
        settled_r <= 1'b0;
      end else if (timer_hit && (st_r == ST_SETTLE)) begin
        settled_r <= 1'b1;
      end
    end
  end

  // decoded setup, registered so outputs come from flops
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      direct_r <= 1'b0;
      ratio_r <= 15'h0000;
      sinc51_r <= 1'b1;
      sinc3_r <= 1'b0;
      pf_on_r <= 1'b0;
      pf_choice_r <= 3'h5;
      rate_r <= 5'h00;
    end else begin
      direct_r <= in_direct;
      ratio_r <= in_direct ? cfg_r[`FSC_RATIO_MSB:0] : 15'h0000;
      sinc51_r <= !in_direct &&
        (cfg_r[`FSC_ORDER_MSB:`FSC_ORDER_LSB] == `FSC_ORDER_SINC5_SINC1);
      sinc3_r <= in_direct ||
        (cfg_r[`FSC_ORDER_MSB:`FSC_ORDER_LSB] == `FSC_ORDER_SINC3);
      pf_on_r <= pf_live;
      pf_choice_r <= cfg_r[`FSC_PF_CHOICE_MSB:`FSC_PF_CHOICE_LSB];
      rate_r <= in_direct ? 5'h00
                          : cfg_r[`FSC_RATE_MSB:`FSC_RATE_LSB];
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_r;
  assign conv_restart = restart_r;
  assign word_ready = word_r;
  assign conv_settled = settled_r;
  assign direct_decimation_select = direct_r;
  assign decim_ratio = ratio_r;
  assign order_sinc5_sinc1 = sinc51_r;
  assign order_sinc3 = sinc3_r;
  assign mains_postfilter_on = pf_on_r;
  assign mains_postfilter_choice = pf_choice_r;
  assign output_rate_field = rate_r;

endmodule

`default_nettype wire

// ==== hdl/fsc_filter_regs.vh ====
// constants for the setup filter configuration block
`ifndef FSC_FILTER_REGS_VH
`define FSC_FILTER_REGS_VH

// register map
`define FSC_ADDR_FILTER_CFG 6'h28
`define FSC_RST_FILTER_CFG 16'h0500
`define FSC_RD_UNMAPPED 16'h0000

// field positions
`define FSC_DIRECT_BIT 15
`define FSC_RSV_HI_MSB 14
`define FSC_RSV_HI_LSB 12
`define FSC_PF_EN_BIT 11
`define FSC_PF_CHOICE_MSB 10
`define FSC_PF_CHOICE_LSB 8
`define FSC_RSV_LO_BIT 7
`define FSC_ORDER_MSB 6
`define FSC_ORDER_LSB 5
`define FSC_RATE_MSB 4
`define FSC_RATE_LSB 0
`define FSC_RATIO_MSB 14

// writable bits per mapping
`define FSC_NORMAL_WMASK 16'h8F7F
`define FSC_DIRECT_WMASK 16'hFFFF

// filter order codes
`define FSC_ORDER_SINC5_SINC1 2'h0
`define FSC_ORDER_SINC3 2'h3

// post-filter codes
`define FSC_PF_27 3'h2
`define FSC_PF_21 3'h3
`define FSC_PF_20 3'h5
`define FSC_PF_16 3'h6

// timing: clock, settling in us, rates in centi-SPS
`define FSC_CLK_HZ 40000000
`define FSC_CLK_MHZ 40
`define FSC_SETTLE_27_US 36700
`define FSC_SETTLE_21_US 40000
`define FSC_SETTLE_20_US 50000
`define FSC_SETTLE_16_US 60000
`define FSC_RATE_27_CSPS 2700
`define FSC_RATE_21_CSPS 2125
`define FSC_RATE_20_CSPS 2000
`define FSC_RATE_16_CSPS 1667
`define FSC_CSPS_PER_SPS 100

// modulator tick divider and direct-mode scaling
`define FSC_MOD_DIV 6'd40
`define FSC_DIRECT_MUL 24'd32
`define FSC_SINC3_SETTLE_WORDS 3
`define FSC_PLAIN_WORD_CYC 8000

`endif

// ==== hdl/fsc_word_timer.v ====
// output word timer: counts ticks up to a target, pulses on reach
`timescale 1ns/1ps
`default_nettype none

module fsc_word_timer (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // control
  input wire clear,
  input wire tick,
  input wire [23:0] target,
  // result
  output reg hit_r
);

  reg [23:0] cnt_r;
  wire [23:0] cnt_inc;

  assign cnt_inc = cnt_r + 24'h000001;

  // zero target parks the timer, so undefined settings give no words
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 24'h000000;
      hit_r <= 1'b0;
    end else if (clear) begin
      cnt_r <= 24'h000000;
      hit_r <= 1'b0;
    end else if (tick && (target != 24'h000000)) begin
      if (cnt_inc >= target) begin
        cnt_r <= 24'h000000;
        hit_r <= 1'b1;
      end else begin
        cnt_r <= cnt_inc;
        hit_r <= 1'b0;
      end
    end else begin
      hit_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== test/fsc_filter_cfg_chk.sv ====
// assertions for the setup filter configuration block
`timescale 1ns/1ps
`default_nettype none
`include "fsc_filter_regs.vh"
module fsc_filter_cfg_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register access
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rdata,
  // conversion control
  input wire logic conv_restart,
  input wire logic word_ready,
  input wire logic conv_settled,
  // decoded setup
  input wire logic direct_decimation_select,
  input wire logic [14:0] decim_ratio,
  input wire logic order_sinc5_sinc1,
  input wire logic order_sinc3,
  input wire logic mains_postfilter_on,
  input wire logic [2:0] mains_postfilter_choice,
  input wire logic [4:0] output_rate_field
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // write strobe aimed at the filter register
  wire wr_hit = reg_wr_en && reg_addr == `FSC_ADDR_FILTER_CFG;
  sequence s_wr;
    wr_hit;
  endsequence
  sequence s_pulse;
    conv_restart ##1 !conv_restart;
  endsequence
  property p_restart;
    s_wr ##1 !reg_wr_en |-> s_pulse;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart pulse");
  property p_no_spur;
    !wr_hit |=> !conv_restart;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("stray restart");
  property p_settle_clr;
    s_wr |=> !conv_settled;
  endproperty
  a_settle_clr: assert property (p_settle_clr) else $error("settled kept");
  property p_unmapped;
    reg_rd_en && reg_addr != `FSC_ADDR_FILTER_CFG |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  // reserved bits read zero unless the direct mapping owns them
  property p_rsv;
    reg_rd_en |=> reg_rdata[15] || (reg_rdata[14:12] == 3'h0 && !reg_rdata[7]);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_decode;
    s_wr |-> ##2 direct_decimation_select == $past(reg_wdata[15], 2) &&
      decim_ratio == ($past(reg_wdata[15], 2) ? $past(reg_wdata[14:0], 2) : 15'h0000);
  endproperty
  a_decode: assert property (p_decode) else $error("direct decode");
  property p_ignore;
    direct_decimation_select |-> order_sinc3 && !order_sinc5_sinc1 &&
      !mains_postfilter_on && output_rate_field == 5'h00;
  endproperty
  a_ignore: assert property (p_ignore) else $error("fields not ignored");
  property p_pf_gate;
    mains_postfilter_on |-> order_sinc5_sinc1;
  endproperty
  a_pf_gate: assert property (p_pf_gate) else $error("postfilter ungated");
  property p_pf;
    s_wr |-> ##2 mains_postfilter_choice == $past(reg_wdata[10:8], 2) &&
      mains_postfilter_on == ($past(reg_wdata[11], 2) && !$past(reg_wdata[15], 2) &&
      $past(reg_wdata[6:5], 2) == 2'h0);
  endproperty
  a_pf: assert property (p_pf) else $error("postfilter decode");
endmodule
bind fsc_filter_cfg fsc_filter_cfg_chk u_chk (.core_clk, .rst_n, .reg_addr, .reg_wr_en,
  .reg_wdata, .reg_rd_en, .reg_rdata, .conv_restart, .word_ready, .conv_settled,
  .direct_decimation_select, .decim_ratio, .order_sinc5_sinc1, .order_sinc3,
  .mains_postfilter_on, .mains_postfilter_choice, .output_rate_field);
`default_nettype wire

// ==== test/tb_fsc_filter_cfg.sv ====
// self-checking bench for the setup filter configuration block
`timescale 1ns/1ps
`default_nettype none
`include "fsc_filter_regs.vh"
module tb_fsc_filter_cfg;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr_en = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_rdata;
  logic conv_restart, word_ready, conv_settled, direct_decimation_select;
  logic [14:0] decim_ratio;
  logic order_sinc5_sinc1, order_sinc3, mains_postfilter_on;
  logic [2:0] mains_postfilter_choice;
  logic [4:0] output_rate_field;
  logic [2:0] codes [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
  // post-filter pace divided down so the run stays brief
  localparam logic [31:0] DIV = 32'd50000;
  int settle_exp [4] = '{`FSC_SETTLE_27_US * `FSC_CLK_MHZ / DIV,
    `FSC_SETTLE_21_US * `FSC_CLK_MHZ / DIV, `FSC_SETTLE_20_US * `FSC_CLK_MHZ / DIV,
    `FSC_SETTLE_16_US * `FSC_CLK_MHZ / DIV};
  longint word_exp [4] = '{64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_27_CSPS / DIV,
    64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_21_CSPS / DIV,
    64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_20_CSPS / DIV,
    64'd`FSC_CLK_HZ * `FSC_CSPS_PER_SPS / `FSC_RATE_16_CSPS / DIV};
  int mismatches = 0;
  int n_checks = 0;
  int n;
  // pacing counts shortened so the run stays brief
  fsc_filter_cfg #(.TIME_DIV(DIV), .PLAIN_WORD_CYC(32'd20)) dut (
    .core_clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .conv_restart, .word_ready, .conv_settled, .direct_decimation_select, .decim_ratio,
    .order_sinc5_sinc1, .order_sinc3, .mains_postfilter_on, .mains_postfilter_choice,
    .output_rate_field);
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes rise and fall on falling edges, so each is seen by exactly one rising edge
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk(reg_rdata, e);
  endtask
  // bounded wait for the next output word, counting falling edges
  task automatic wait_word();
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!word_ready && n < 20000);
  endtask
  function automatic logic [11:0] dcd();
    return {direct_decimation_select, order_sinc5_sinc1, order_sinc3, mains_postfilter_on,
      mains_postfilter_choice, output_rate_field};
  endfunction
  // expected decode of a stored word
  function automatic logic [11:0] fn(input logic [15:0] d);
    logic s5;
    s5 = !d[15] && d[6:5] == 2'h0;
    return {d[15], s5, d[15] || d[6:5] == 2'h3, d[11] && s5, d[10:8],
      d[15] ? 5'h00 : d[4:0]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog well beyond the direct-mode word times
  initial begin
    #2000000;
    mismatches++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    rd(`FSC_ADDR_FILTER_CFG, `FSC_RST_FILTER_CFG);
    chk(dcd(), fn(16'h0500));
    rd(6'h29, 16'h0000);
    wr(`FSC_ADDR_FILTER_CFG, 16'h7FFF);
    chk(conv_restart, 1'b1);
    rd(`FSC_ADDR_FILTER_CFG, 16'h0F7F);
    chk(dcd(), fn(16'h0F7F));
    wr(6'h29, 16'h1234);
    chk(conv_restart, 1'b0);
    rd(`FSC_ADDR_FILTER_CFG, 16'h0F7F);
    // each listed post-filter: settle, then word period
    for (int i = 0; i < 4; i++) begin
      wr(`FSC_ADDR_FILTER_CFG, {5'h01, codes[i], 8'h0A});
      chk(conv_settled, 1'b0);
      // first word lags the settle count by the restart and timer stages
      wait_word();
      chk(n, settle_exp[i] + 2);
      chk(dcd(), fn({5'h01, codes[i], 8'h0A}));
      wait_word();
      chk(n, word_exp[i]);
      chk(conv_settled, 1'b1);
    end
    // direct mapping keeps every low bit and overrides the fields
    wr(`FSC_ADDR_FILTER_CFG, 16'hF0FF);
    rd(`FSC_ADDR_FILTER_CFG, 16'hF0FF);
    chk({dcd(), decim_ratio}, {fn(16'hF0FF), 15'h70FF});
    wr(`FSC_ADDR_FILTER_CFG, 16'h8003);
    wait_word();
    chk(n >= 3 * 3840 - 45 && n <= 3 * 3840 + 45, 1'b1);
    wait_word();
    chk(n >= 3838 && n <= 3842, 1'b1);
    // reset in mid-run drops the direct mapping and restores defaults
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({conv_settled, direct_decimation_select, decim_ratio}, 17'h00000);
    rst_n = 1'b1;
    rd(`FSC_ADDR_FILTER_CFG, `FSC_RST_FILTER_CFG);
    chk({dcd(), decim_ratio}, {fn(`FSC_RST_FILTER_CFG), 15'h0000});
    give_verdict();
  end
endmodule
`default_nettype wire
